// [src/scrf_pkg.sv]
// Constants, types and helpers for the serial command front end.
// Assumes one system clock; all link pins are sampled asynchronously.
package scrf_pkg;
	localparam int          SCRF_CMD_W       = 8;
	localparam int          SCRF_RESET_ONES  = 32;
	localparam int          SCRF_RW_BIT      = 6;
	localparam int          SCRF_RS_HI       = 5;
	localparam int          SCRF_RS_LO       = 3;
	localparam int          SCRF_CONTINUOUS_READOUT_BIT_BIT   = 2;
	localparam int          SCRF_CMD_TAIL    = 7;
	localparam int          SCRF_MON_BITS    = 8;
	localparam logic [7:0]  SCRF_CMD_RESET   = 8'h00;
	localparam logic [7:0]  SCRF_CONTINUOUS_READOUT_BIT_ENTER = 8'h5C;
	localparam logic [7:0]  SCRF_CONTINUOUS_READOUT_BIT_EXIT  = 8'h58;
	localparam logic [2:0]  SCRF_RS_COMM     = 3'h0;
	localparam logic [2:0]  SCRF_RS_MODE     = 3'h1;
	localparam logic [2:0]  SCRF_RS_CONF     = 3'h2;
	localparam logic [2:0]  SCRF_RS_DATA     = 3'h3;
	localparam logic [2:0]  SCRF_RS_ID       = 3'h4;
	localparam logic [2:0]  SCRF_RS_IO       = 3'h5;
	localparam logic [2:0]  SCRF_RS_OFFS     = 3'h6;
	localparam logic [2:0]  SCRF_RS_FS       = 3'h7;
	localparam int          SCRF_LEN_BYTE    = 8;
	localparam int          SCRF_LEN_WORD    = 16;

	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WRITE, ST_LOAD, ST_READ, ST_CONTINUOUS_READOUT_BIT} scrf_state_t;

	// Transfer length in bits for each register select
	function automatic int scrf_len(input logic [2:0] rs, input int wide_w);
		case (rs)
			SCRF_RS_MODE, SCRF_RS_CONF:             scrf_len = SCRF_LEN_WORD;
			SCRF_RS_DATA, SCRF_RS_OFFS, SCRF_RS_FS: scrf_len = wide_w;
			default:                                scrf_len = SCRF_LEN_BYTE;
		endcase
	endfunction
endpackage

// [src/scrf_front_end.sv]
// Serial command front end: gate bit, command byte, one register transfer.
// Assumes sclk/din/cs_n come from a host; the register core answers a read
// request with read_data_in on the next clock and drives data_ready_n_in.
`timescale 1ns/1ps
module scrf_front_end
	import scrf_pkg::*;
#(
	parameter int DATA_W = 24
)
(
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              sclk_in,
	input  wire logic              din_in,
	input  wire logic              cs_n_in,
	input  wire logic              data_ready_n_in,
	input  wire logic [DATA_W-1:0] read_data_in,
	output logic                   dout_out,
	output logic [2:0]             reg_addr_out,
	output logic                   reg_wr_out,
	output logic                   reg_rd_out,
	output logic [DATA_W-1:0]      reg_wdata_out,
	output logic                   part_reset_out,
	output logic                   continuous_readout_bit_active_out
);
	initial
	begin
		if (DATA_W < SCRF_LEN_WORD || DATA_W > 31)
			$error("DATA_W must lie between 16 and 31");
	end
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge finding
	logic              sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic              din_s1_q, din_s2_q;
	logic              cs_s1_q, cs_s2_q;
	logic              rdy_n_last_q;
	logic              rise, fall, active, bit_in, ones_full;
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sclk_s1_q <= 1'b1;
			sclk_s2_q <= 1'b1;
			sclk_s3_q <= 1'b1;
			din_s1_q  <= 1'b0;
			din_s2_q  <= 1'b0;
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			rdy_n_last_q <= 1'b1;
		end
		else
		begin
			sclk_s1_q <= sclk_in;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			din_s1_q  <= din_in;
			din_s2_q  <= din_s1_q;
			cs_s1_q   <= cs_n_in;
			cs_s2_q   <= cs_s1_q;
			rdy_n_last_q <= data_ready_n_in;
		end
	end
	assign active = !cs_s2_q;
	assign rise   = active && sclk_s2_q && !sclk_s3_q;
	assign fall   = active && !sclk_s2_q && sclk_s3_q;
	assign bit_in = din_s2_q;
	////////////////////////////////////////////////////////////////////////
	// Run of ones; the thirty-second high bit resets the part
	logic [5:0] ones_q;
	logic       part_reset_q;
	assign ones_full = (ones_q == 6'(SCRF_RESET_ONES - 1)) && rise && bit_in;
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ones_q       <= 6'h00;
			part_reset_q <= 1'b0;
		end
		else
		begin
			part_reset_q <= ones_full;
			if (ones_full)
				ones_q <= 6'h00;
			else if (rise)
				ones_q <= bit_in ? ones_q + 6'h01 : 6'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Command interpreter
	scrf_state_t       state_q;
	logic [7:0]        cmd_q;
	logic [6:0]        tail_q;
	logic [4:0]        left_q;
	logic [DATA_W-1:0] sh_q;
	logic [7:0]        mon_q;
	logic [3:0]        mon_cnt_q;
	logic              continuous_readout_bit_q, wr_q, rd_q, dout_q;
	logic [2:0]        addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [7:0]        cmd_full;
	logic [7:0]        mon_full;
	logic [2:0]        cmd_rs;
	assign cmd_full = {1'b0, tail_q[5:0], bit_in};
	assign cmd_rs   = cmd_full[SCRF_RS_HI:SCRF_RS_LO];
	assign mon_full = {mon_q[6:0], bit_in};
	// Read data is left aligned so the top bit of any size goes out first
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			state_q   <= ST_IDLE;
			cmd_q     <= SCRF_CMD_RESET;
			tail_q    <= 7'h00;
			left_q    <= 5'h00;
			sh_q      <= '0;
			mon_q     <= 8'h00;
			mon_cnt_q <= 4'h0;
			continuous_readout_bit_q   <= 1'b0;
			wr_q      <= 1'b0;
			rd_q      <= 1'b0;
			addr_q    <= SCRF_RS_COMM;
			wdata_q   <= '0;
		end
		else if (ones_full)
		begin
			state_q   <= ST_IDLE;
			cmd_q     <= SCRF_CMD_RESET;
			continuous_readout_bit_q   <= 1'b0;
			mon_cnt_q <= 4'h0;
			wr_q      <= 1'b0;
			rd_q      <= 1'b0;
		end
		else
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (rise && !bit_in)
					begin
						state_q <= ST_CMD;
						left_q  <= 5'(SCRF_CMD_TAIL);
						tail_q  <= 7'h00;
						sh_q    <= '0;
					end
				end
				ST_CMD:
				begin
					if (rise)
					begin
						tail_q <= {tail_q[5:0], bit_in};
						left_q <= left_q - 5'h01;
						if (left_q == 5'h01)
						begin
							cmd_q  <= cmd_full;
							addr_q <= cmd_rs;
							left_q <= 5'(scrf_len(cmd_rs, DATA_W));
							if (cmd_full == SCRF_CONTINUOUS_READOUT_BIT_ENTER)
							begin
								continuous_readout_bit_q   <= 1'b1;
								mon_cnt_q <= 4'h0;
								state_q   <= ST_CONTINUOUS_READOUT_BIT;
							end
							else if (cmd_full[SCRF_RW_BIT])
							begin
								rd_q    <= 1'b1;
								state_q <= ST_LOAD;
							end
							else if (cmd_rs == SCRF_RS_COMM)
								state_q <= ST_IDLE;
							else
								state_q <= ST_WRITE;
						end
					end
				end
				ST_WRITE:
				begin
					if (rise)
					begin
						sh_q   <= {sh_q[DATA_W-2:0], bit_in};
						left_q <= left_q - 5'h01;
						if (left_q == 5'h01)
						begin
							wr_q    <= 1'b1;
							wdata_q <= {sh_q[DATA_W-2:0], bit_in};
							state_q <= ST_IDLE;
						end
					end
				end
				ST_LOAD:
				begin
					sh_q    <= read_data_in << (DATA_W - scrf_len(addr_q, DATA_W));
					state_q <= ST_READ;
				end
				ST_READ:
				begin
					if (fall)
						sh_q <= {sh_q[DATA_W-2:0], 1'b0};
					if (rise)
					begin
						left_q <= left_q - 5'h01;
						if (left_q == 5'h01)
							state_q <= continuous_readout_bit_q ? ST_CONTINUOUS_READOUT_BIT : ST_IDLE;
					end
				end
				ST_CONTINUOUS_READOUT_BIT:
				begin
					if (rdy_n_last_q && !data_ready_n_in)
					begin
						addr_q    <= SCRF_RS_DATA;
						left_q    <= 5'(scrf_len(SCRF_RS_DATA, DATA_W));
						rd_q      <= 1'b1;
						mon_cnt_q <= 4'h0;
						state_q   <= ST_LOAD;
					end
					else if (rise)
					begin
						mon_q     <= mon_full;
						mon_cnt_q <= mon_cnt_q + 4'h1;
						if (mon_cnt_q == 4'(SCRF_MON_BITS - 1))
						begin
							mon_cnt_q <= 4'h0;
							if (mon_full == SCRF_CONTINUOUS_READOUT_BIT_EXIT && !data_ready_n_in)
							begin
								continuous_readout_bit_q <= 1'b0;
								cmd_q   <= mon_full;
								state_q <= ST_IDLE;
							end
						end
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end
	// The output pin moves only on the host's falling edge
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			dout_q <= 1'b1;
		else if (fall && state_q == ST_READ)
			dout_q <= sh_q[DATA_W-1];
	end
	assign dout_out         = dout_q;
	assign reg_addr_out     = addr_q;
	assign reg_wr_out       = wr_q;
	assign reg_rd_out       = rd_q;
	assign reg_wdata_out    = wdata_q;
	assign part_reset_out   = part_reset_q;
	assign continuous_readout_bit_active_out = continuous_readout_bit_q;
	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_serial_reset: assert property (ones_full |=> part_reset_q && state_q == ST_IDLE)
		else $error("Serial reset not taken");
	a_cmd_cleared: assert property (part_reset_q |-> cmd_q == SCRF_CMD_RESET && !continuous_readout_bit_q)
		else $error("Command register not cleared");
	a_gate_hold: assert property (state_q == ST_IDLE && rise && bit_in && !ones_full
		|=> state_q == ST_IDLE)
		else $error("Gate bit 1 left idle");
	a_gate_start: assert property (state_q == ST_IDLE && rise && !bit_in |=> state_q == ST_CMD)
		else $error("Gate bit 0 ignored");
	a_dout_falling: assert property (!fall |=> $stable(dout_q))
		else $error("Output moved off a falling edge");
	a_write_dir: assert property (wr_q |-> !cmd_q[SCRF_RW_BIT] && state_q == ST_IDLE)
		else $error("Write without write command");
	a_read_dir: assert property (rd_q && !continuous_readout_bit_q |-> cmd_q[SCRF_RW_BIT] ##1 state_q == ST_READ)
		else $error("Read without read command");
	a_addr_match: assert property (wr_q || rd_q |-> addr_q == cmd_q[SCRF_RS_HI:SCRF_RS_LO])
		else $error("Target differs from select bits");
	c_write_done: cover property (wr_q);
	c_read_done: cover property (state_q == ST_READ ##1 state_q == ST_IDLE);
	c_continuous_readout_bit_entry: cover property ($rose(continuous_readout_bit_q));
	c_serial_reset: cover property (part_reset_q);
endmodule // scrf_front_end

// [verif/scrf_host_model.sv]
// Host side of the serial link: drives clock, data and select.
// Assumes a free-running system clock; link clock idles high between frames.
`timescale 1ns/1ps
module scrf_host_model
(
	input  wire logic clk_in,
	input  wire logic dout_in,
	output logic      sclk_out,
	output logic      din_out,
	output logic      cs_n_out
);
	initial
	begin
		sclk_out = 1'b1;
		din_out  = 1'b0;
		cs_n_out = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// One frame, MSB first; output sampled late in the high phase
	// because the device answers through synchronisers
	task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = '0;
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk_out <= 1'b0;
			din_out  <= tx[i];
			repeat (4) @(posedge clk_in);
			sclk_out <= 1'b1;
			repeat (3) @(posedge clk_in);
			rx[i] = dout_in;
			@(posedge clk_in);
		end
		cs_n_out <= 1'b1;
		// Released line shows a changed level, not the last bit
		din_out  <= ~tx[0];
	endtask
endmodule // scrf_host_model

// [verif/serial_command_register_front_end_tb_top.sv]
// Self-checking bench for the serial command front end.
// Assumes the host model drives the link; the bench plays the register core.
`timescale 1ns/1ps
module serial_command_register_front_end_tb_top;
	import scrf_pkg::*;
	localparam int DW = 24;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        sclk, din, cs_n, dout, reg_wr, reg_rd, part_reset, continuous_readout_bit;
	logic        data_ready_n = 1'b1;
	logic [DW-1:0] read_data = '0;
	logic [DW-1:0] reg_wdata, lw;
	logic [2:0]  reg_addr, la;
	logic [31:0] rx, msk;
	logic [7:0]  cmd;
	int          n_mismatch, n_tests, n_wr, n_rd, n_prst, cyc, len, ev0, rd0;
	logic [31:0] rows [13] = '{32'h08001234, 32'h1000BEEF, 32'h2800005A, 32'h3089ABCD,
		32'h387E5A3C, 32'h400000C3, 32'h4800A5F0, 32'h50000F96, 32'h5896A55A,
		32'h6000003C, 32'h68000081, 32'h70F00F1E, 32'h785AA5C3};
	always #50 clk_in = ~clk_in;
	scrf_front_end #(.DATA_W(DW)) dut (.clk_in(clk_in), .reset_in(reset_in),
		.sclk_in(sclk), .din_in(din), .cs_n_in(cs_n), .data_ready_n_in(data_ready_n),
		.read_data_in(read_data), .dout_out(dout), .reg_addr_out(reg_addr),
		.reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata),
		.part_reset_out(part_reset), .continuous_readout_bit_active_out(continuous_readout_bit));
	scrf_host_model host (.clk_in(clk_in), .dout_in(dout), .sclk_out(sclk),
		.din_out(din), .cs_n_out(cs_n));
	////////////////////////////////////////////////////////////////
	always @(posedge clk_in)
	begin
		cyc = cyc + 1;
		if (reg_wr === 1'b1 || reg_rd === 1'b1)
		begin
			n_wr = n_wr + (reg_wr === 1'b1);
			n_rd = n_rd + (reg_rd === 1'b1);
			la = reg_addr;
			lw = reg_wdata;
		end
		if (part_reset === 1'b1)
			n_prst++;
		if (cyc == 12000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_ev(int prev);
		for (int i = 0; i < 60 && n_wr + n_rd + n_prst == prev; i++)
			@(posedge clk_in);
	endtask
	task automatic wait_continuous_readout_bit(logic lvl);
		for (int i = 0; i < 60 && continuous_readout_bit !== lvl; i++)
			@(posedge clk_in);
	endtask
	function automatic int exp_len(logic [2:0] rs);
		case (rs)
			3'h1, 3'h2:       return 16;
			3'h3, 3'h6, 3'h7: return DW;
			default:          return 8;
		endcase
	endfunction
	task automatic tally_and_finish();
		$display("mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk("dout_rst", dout, 1);
		chk("wdata_rst", reg_wdata, 0);
		chk("continuous_readout_bit_rst", continuous_readout_bit, 0);
		for (int r = 0; r < 13; r++)
		begin
			cmd = rows[r][31:24];
			len = exp_len(cmd[5:3]);
			msk = (32'h1 << len) - 32'h1;
			read_data <= rows[r][23:0];
			ev0 = n_wr + n_rd + n_prst;
			rd0 = n_rd;
			host.shift(8, {24'h0, cmd}, rx);
			host.shift(len, {8'h0, rows[r][23:0]}, rx);
			wait_ev(ev0);
			chk("count", n_wr + n_rd, ev0 + 1);
			chk("dir", n_rd - rd0, cmd[6]);
			chk("addr", la, cmd[5:3]);
			if (cmd[6])
				chk("rdata", rx, rows[r] & msk);
			else
				chk("wdata", lw, rows[r] & msk);
		end
		// Command register write alone: no transfer follows, port back to idle
		ev0 = n_wr + n_rd + n_prst;
		host.shift(8, 32'h00, rx);
		repeat (20) @(posedge clk_in);
		chk("comm_wr", n_wr + n_rd + n_prst, ev0);
		// Gate: 31 ones are ignored, then a normal write
		ev0 = n_wr + n_rd + n_prst;
		host.shift(31, 32'h7FFFFFFF, rx);
		host.shift(24, 32'h084321, rx);
		wait_ev(ev0);
		chk("no_prst", n_prst, 0);
		chk("gate_wd", lw, 32'h4321);
		// Continuous readout, then exit while ready low
		host.shift(8, 32'h5C, rx);
		wait_continuous_readout_bit(1'b1);
		chk("continuous_readout_bit_on", continuous_readout_bit, 1);
		read_data <= 24'h5AC396;
		data_ready_n <= 1'b0;
		ev0 = n_wr + n_rd + n_prst;
		wait_ev(ev0);
		chk("cr_addr", la, 3);
		host.shift(DW, 32'h0, rx);
		chk("cr_data", rx, 32'h5AC396);
		host.shift(8, 32'h58, rx);
		wait_continuous_readout_bit(1'b0);
		chk("continuous_readout_bit_off", continuous_readout_bit, 0);
		data_ready_n <= 1'b1;
		// Exit command with ready high is ignored; serial reset clears the mode
		host.shift(8, 32'h5C, rx);
		wait_continuous_readout_bit(1'b1);
		host.shift(8, 32'h58, rx);
		repeat (8) @(posedge clk_in);
		chk("cr_stay", continuous_readout_bit, 1);
		ev0 = n_wr + n_rd + n_prst;
		host.shift(32, 32'hFFFFFFFF, rx);
		wait_ev(ev0);
		chk("prst", n_prst, 1);
		chk("prst_cr", continuous_readout_bit, 0);
		ev0 = n_wr + n_rd + n_prst;
		host.shift(24, 32'h081357, rx);
		wait_ev(ev0);
		chk("post_wd", lw, 32'h1357);
		// Reset in mid-run while waiting in continuous readout
		host.shift(8, 32'h5C, rx);
		wait_continuous_readout_bit(1'b1);
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		chk("continuous_readout_bit_mid", continuous_readout_bit, 0);
		chk("dout_mid", dout, 1);
		@(posedge clk_in);
		chk("wdata_mid", reg_wdata, 0);
		ev0 = n_wr + n_rd + n_prst;
		host.shift(24, 32'h082468, rx);
		wait_ev(ev0);
		chk("mid_wd", lw, 32'h2468);
		tally_and_finish();
	end
endmodule // serial_command_register_front_end_tb_top
